/* verif/flash_reset_terminate_logic_test.sv */
// Purpose: self-checking bench of the reset and terminate control
// Assumes: short timer parameters, single and octal host frames
// Notes: frames start 3 ns after the preceding step, not tied to a clock edge
`timescale 1ns/100ps
module flash_reset_terminate_logic_test;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_rst_pin_n = 1'b1;
	logic i_op_busy = 1'b0;
	logic i_pe_error = 1'b0;
	logic i_pe_error_clr = 1'b0;
	logic i_wel_set = 1'b0;
	logic i_octal_enter = 1'b0;
	logic sck, cs_n;
	logic [7:0] dq, o_dq, o_dq_oe, rx;
	logic o_octal_mode, o_lowest_power_state, o_busy_flag, o_abort_op;
	logic o_write_enable_latch, o_abort_enable_bit;
	logic o_program_erase_error_flag, o_pe_allowed, o_vol_reset;
	logic o_prot_reset;
	logic vol_seen = 1'b0;
	logic prot_seen = 1'b0;
	logic [7:0] oe_last = 8'h00;
	int fails = 0;
	int cmp_count = 0;

	always #5 i_clk = ~i_clk;

	// the reset pulse lasts one clock, so it is latched here
	always @(posedge i_clk) if (o_vol_reset === 1'b1) vol_seen <= 1'b1;
	always @(posedge i_clk) if (o_prot_reset === 1'b1) prot_seen <= 1'b1;
	// enables stand only while a read shifts, so the last one is kept
	always @(posedge i_clk) if (o_dq_oe !== 8'h00) oe_last <= o_dq_oe;

	frt_host_model host_u (.i_so(o_dq[1]), .o_sck(sck), .o_cs_n(cs_n),
		.o_dq(dq));

	frt_ctrl #(.ABORT_CYC(20), .SWRES_CYC(30), .WAKE_CYC(20), .PUW_CYC(50))
		dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sck(sck),
		.i_cs_n(cs_n), .i_dq(dq), .i_rst_pin_n(i_rst_pin_n),
		.i_op_busy(i_op_busy), .i_pe_error(i_pe_error),
		.i_pe_error_clr(i_pe_error_clr), .i_wel_set(i_wel_set),
		.i_octal_enter(i_octal_enter), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
		.o_octal_mode(o_octal_mode),
		.o_lowest_power_state(o_lowest_power_state),
		.o_busy_flag(o_busy_flag), .o_abort_op(o_abort_op),
		.o_write_enable_latch(o_write_enable_latch),
		.o_abort_enable_bit(o_abort_enable_bit),
		.o_program_erase_error_flag(o_program_erase_error_flag),
		.o_pe_allowed(o_pe_allowed), .o_vol_reset(o_vol_reset),
		.o_prot_reset(o_prot_reset));

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc

	task automatic snd(input logic [15:0] v, input int n, input logic oct);
		#3;
		host_u.xfer(v, n, oct, rx);
	endtask : snd

	task automatic wrap_up();
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		#500000;
		fails++;
		wrap_up();
	end

	initial begin
		logic [15:0] nv [3];
		int nn [3];
		nv = '{16'hF000, 16'hF0D0, 16'hF0D1};
		nn = '{8, 20, 16};
		cyc(7);
		@(posedge i_clk) i_reset_n <= 1'b1;
		cyc(10);
		chk("pe_allowed", 8'h00, o_pe_allowed);
		cyc(45);
		chk("pe_allowed", 8'h01, o_pe_allowed);
		// terminate while disabled, then enable it before the program
		@(posedge i_clk) i_op_busy <= 1'b1;
		snd(16'hF0D0, 16, 1'b0);
		chk("abort", 8'h00, o_abort_op);
		snd(16'h3108, 16, 1'b0);
		chk("abort_en", 8'h01, o_abort_enable_bit);
		@(posedge i_clk) i_wel_set <= 1'b1;
		@(posedge i_clk) i_wel_set <= 1'b0;
		cyc(2);
		chk("wel", 8'h01, o_write_enable_latch);
		for (int k = 0; k < 3; k++) begin
			snd(nv[k], nn[k], 1'b0);
			chk("abort", 8'h00, o_abort_op);
		end
		snd(16'hF0D0, 24, 1'b0);
		chk("abort", 8'h01, o_abort_op);
		chk("wel", 8'h00, o_write_enable_latch);
		chk("abort_en", 8'h01, o_abort_enable_bit);
		cyc(15);
		chk("abort", 8'h00, o_abort_op);
		@(posedge i_clk) i_op_busy <= 1'b0;
		cyc(2);
		// reset enable broken by another opcode must not reset
		chk("busy", 8'h00, o_busy_flag);
		snd(16'h6600, 8, 1'b0);
		snd(16'hF000, 8, 1'b0);
		snd(16'h9900, 8, 1'b0);
		chk("vol_reset", 8'h00, vol_seen);
		chk("prot_reset", 8'h00, prot_seen);
		chk("abort_en", 8'h01, o_abort_enable_bit);
		// reset pair in octal mode
		@(posedge i_clk) i_octal_enter <= 1'b1;
		@(posedge i_clk) i_octal_enter <= 1'b0;
		cyc(2);
		chk("octal", 8'h01, o_octal_mode);
		snd(16'h6600, 1, 1'b1);
		snd(16'h9900, 1, 1'b1);
		chk("vol_reset", 8'h01, vol_seen);
		chk("prot_reset", 8'h01, prot_seen);
		chk("busy", 8'h01, o_busy_flag);
		chk("octal", 8'h00, o_octal_mode);
		chk("abort_en", 8'h00, o_abort_enable_bit);
		cyc(30);
		chk("busy", 8'h00, o_busy_flag);
		// lowest power: select activity, status read, ignored write, resume
		@(posedge i_clk) i_pe_error <= 1'b1;
		@(posedge i_clk) i_pe_error <= 1'b0;
		snd(16'h7900, 8, 1'b0);
		chk("lps", 8'h01, o_lowest_power_state);
		snd(16'h0000, 0, 1'b0);
		chk("lps", 8'h01, o_lowest_power_state);
		snd(16'h0500, 16, 1'b0);
		chk("status", 8'hFF, rx);
		chk("dq_oe", 8'h02, oe_last);
		chk("dq_oe", 8'h00, o_dq_oe);
		snd(16'h3108, 16, 1'b0);
		chk("abort_en", 8'h00, o_abort_enable_bit);
		snd(16'hAB00, 8, 1'b0);
		cyc(30);
		chk("lps", 8'h00, o_lowest_power_state);
		chk("busy", 8'h00, o_busy_flag);
		chk("pe_err", 8'h01, o_program_erase_error_flag);
		// in-band reset out of lowest power entered in octal mode
		@(posedge i_clk) i_octal_enter <= 1'b1;
		@(posedge i_clk) i_octal_enter <= 1'b0;
		snd(16'h7900, 1, 1'b1);
		chk("lps", 8'h01, o_lowest_power_state);
		#3;
		host_u.inband();
		cyc(10);
		chk("lps", 8'h00, o_lowest_power_state);
		chk("octal", 8'h00, o_octal_mode);
		chk("pe_err", 8'h01, o_program_erase_error_flag);
		cyc(35);
		// reset pin out of lowest power, held low then released
		snd(16'h7900, 8, 1'b0);
		chk("lps", 8'h01, o_lowest_power_state);
		@(posedge i_clk) i_rst_pin_n <= 1'b0;
		cyc(8);
		chk("lps", 8'h00, o_lowest_power_state);
		chk("abort", 8'h01, o_abort_op);
		cyc(20);
		chk("busy", 8'h01, o_busy_flag);
		@(posedge i_clk) i_rst_pin_n <= 1'b1;
		cyc(8);
		chk("busy", 8'h00, o_busy_flag);
		@(posedge i_clk) i_pe_error <= 1'b1;
		@(posedge i_clk) i_pe_error <= 1'b0;
		@(posedge i_clk) i_pe_error_clr <= 1'b1;
		@(posedge i_clk) i_pe_error_clr <= 1'b0;
		cyc(2);
		chk("pe_err", 8'h00, o_program_erase_error_flag);
		wrap_up();
	end
endmodule : flash_reset_terminate_logic_test

/* verif/frt_host_model.sv */
// Purpose: host controller model driving the serial command bus
// Assumes: sck mode 0, 160 ns period, running only inside frames
// Notes: data lines flip after release so stale values never help
`timescale 1ns/100ps
module frt_host_model (
	input wire logic i_so,
	output logic o_sck,
	output logic o_cs_n,
	output logic [7:0] o_dq
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_dq = 8'h00;
	end

	// n sck rises; single mode shifts v msb first on dq0, octal sends
	// one byte a rise; bits past 16 are zero; rx samples from rise nine
	task automatic xfer(input logic [15:0] v, input int n, input logic oct,
		output logic [7:0] rx);
		rx = 8'h00;
		o_cs_n = 1'b0;
		#80;
		for (int i = 0; i < n; i++) begin
			if (oct) o_dq = (i == 0) ? v[15:8] : v[7:0];
			else o_dq = {o_dq[7:1], (i < 16) ? v[15 - i] : 1'b0};
			#80;
			if (i >= 8) rx = {rx[6:0], i_so};
			o_sck = 1'b1;
			#80;
			o_sck = 1'b0;
		end
		#80;
		o_cs_n = 1'b1;
		o_dq = ~o_dq;
		#160;
	endtask : xfer

	// four select pulses with sck held still; si held across each rise
	task automatic inband();
		for (int i = 0; i < 4; i++) begin
			o_dq[0] = i[0];
			#40;
			o_cs_n = 1'b0;
			#160;
			o_cs_n = 1'b1;
			#160;
		end
		o_dq = ~o_dq;
	endtask : inband
endmodule : frt_host_model

/* verilog/frt_ctrl.sv */
// Purpose: wake, terminate and software reset control of a serial flash
// Assumes: i_sck only toggles while i_cs_n is low
// Notes: frame decode runs on i_clk from synchronised pins
`timescale 1ns/100ps
`include "frt_defs.svh"
module frt_ctrl #(
	parameter int ABORT_CYC = `FRT_ABORT_CYC,
	parameter int SWRES_CYC = `FRT_SWRES_CYC,
	parameter int WAKE_CYC = `FRT_WAKE_CYC,
	parameter int PUW_CYC = `FRT_PUW_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [7:0] i_dq,
	input wire logic i_rst_pin_n,
	input wire logic i_op_busy,
	input wire logic i_pe_error,
	input wire logic i_pe_error_clr,
	input wire logic i_wel_set,
	input wire logic i_octal_enter,
	output logic [7:0] o_dq,
	output logic [7:0] o_dq_oe,
	output logic o_octal_mode,
	output logic o_lowest_power_state,
	output logic o_busy_flag,
	output logic o_abort_op,
	output logic o_write_enable_latch,
	output logic o_abort_enable_bit,
	output logic o_program_erase_error_flag,
	output logic o_pe_allowed,
	output logic o_vol_reset,
	output logic o_prot_reset
);
	frt_pkg::frt_state_t state;
	logic lk_tog;
	logic [7:0] lk_dat;
	logic cs_s;
	logic sck_s;
	logic si_s;
	logic rpin_s;
	logic tog_s;
	logic cs_q;
	logic sck_q;
	logic tog_q;
	logic [2:0] bit_cnt;
	logic [1:0] byte_cnt;
	logic [7:0] sh_in;
	logic byte_done;
	logic [7:0] op;
	logic [7:0] arg;
	logic armed;
	logic rst_go;
	logic rd_on;
	logic [7:0] sh_out;
	logic [2:0] ib_hist;
	logic [1:0] ib_cnt;
	logic ib_go;
	logic [19:0] tmr;
	logic [19:0] ab_cnt;
	logic [19:0] puw_cnt;
	logic [7:0] sb1;

	// link side: capture each rising edge and flip a toggle;
	// the data stays put for a whole clock period, so the
	// toggle alone needs synchronising
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			lk_tog <= 1'b0;
		end else begin
			lk_tog <= ~lk_tog;
		end
	end

	always_ff @(posedge i_sck) begin
		lk_dat <= i_dq;
	end

	frt_sync #(
		.W(4),
		.INIT(`FRT_SYNC_INIT)
	) u_pins (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_d({i_cs_n, i_sck, i_dq[`FRT_DQ_SI], i_rst_pin_n}),
		.o_q({cs_s, sck_s, si_s, rpin_s})
	);

	frt_sync #(
		.W(1),
		.INIT(1'b0)
	) u_tog (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_d(lk_tog),
		.o_q(tog_s)
	);

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cs_q <= 1'b1;
			sck_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			cs_q <= cs_s;
			sck_q <= sck_s;
			tog_q <= cs_s ? 1'b0 : tog_s;
		end
	end

	wire frm_start = cs_q & ~cs_s;
	wire frm_end = ~cs_q & cs_s;
	wire edge_ev = ~cs_s & (tog_s != tog_q);
	wire sck_chg = sck_s != sck_q;
	wire sck_fall = sck_q & ~sck_s;
	wire idle = state == frt_pkg::ST_IDLE;
	wire in_lps = state == frt_pkg::ST_LPS;

	// byte assembly; octal mode takes a byte per edge
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || frm_start) begin
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
			sh_in <= 8'h00;
		end else begin
			byte_done <= 1'b0;
			if (edge_ev) begin
				if (o_octal_mode) begin
					sh_in <= lk_dat;
					byte_done <= 1'b1;
				end else begin
					sh_in <= {sh_in[6:0], lk_dat[`FRT_DQ_SI]};
					bit_cnt <= bit_cnt + 3'h1;
					byte_done <= bit_cnt == 3'h7;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n || frm_start) begin
			byte_cnt <= 2'h0;
			op <= 8'h00;
			arg <= 8'h00;
		end else if (byte_done && byte_cnt != 2'h2) begin
			byte_cnt <= byte_cnt + 2'h1;
			if (byte_cnt == 2'h0) begin
				op <= sh_in;
			end else begin
				arg <= sh_in;
			end
		end
	end

	// reset enable arms; the next opcode either fires or disarms
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !idle) begin
			armed <= 1'b0;
			rst_go <= 1'b0;
		end else if (byte_done && byte_cnt == 2'h0) begin
			rst_go <= armed && sh_in == `FRT_OP_RST;
			armed <= sh_in == `FRT_OP_RST_EN;
		end
	end

	wire fe_ok = frm_end && bit_cnt == 3'h0 && byte_cnt != 2'h0;
	wire do_term = fe_ok && idle && op == `FRT_OP_TERM &&
		byte_cnt == 2'h2 && arg == `FRT_OP_CONFIRM &&
		o_abort_enable_bit;
	wire do_swr = fe_ok && idle && rst_go;
	wire do_wr2 = fe_ok && idle && op == `FRT_OP_WR_SB2 &&
		byte_cnt == 2'h2;
	wire do_lps = fe_ok && idle && op == `FRT_OP_LPS && !i_op_busy;
	wire do_resume = fe_ok && in_lps && op == `FRT_OP_RESUME;
	wire clr_vol = !rpin_s || do_swr || ib_go || do_resume;
	wire stop_ops = do_term || do_swr || ib_go || !rpin_s;

	// in-band reset: four chip select rises with no clock edge
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || sck_chg) begin
			ib_hist <= 3'h0;
			ib_cnt <= 2'h0;
			ib_go <= 1'b0;
		end else begin
			ib_go <= 1'b0;
			if (frm_end) begin
				if (ib_cnt == 2'h3 &&
					{ib_hist, si_s} == `FRT_INBAND_PAT) begin
					ib_go <= 1'b1;
					ib_cnt <= 2'h0;
				end else begin
					ib_hist <= {ib_hist[1:0], si_s};
					ib_cnt <= (ib_cnt == 2'h3) ? ib_cnt : ib_cnt + 2'h1;
				end
			end
		end
	end

	// chip select alone leaves the lowest power state only through the
	// in-band reset pattern, so a plain status poll does not wake the part
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state <= frt_pkg::ST_IDLE;
			tmr <= 20'h0;
		end else if (!rpin_s) begin
			state <= frt_pkg::ST_HOLD;
			tmr <= 20'h0;
		end else begin
			case (state)
				frt_pkg::ST_IDLE: begin
					if (do_swr || ib_go) begin
						state <= frt_pkg::ST_SWRST;
						tmr <= 20'(SWRES_CYC);
					end else if (do_lps) begin
						state <= frt_pkg::ST_LPS;
					end
				end
				frt_pkg::ST_LPS: begin
					if (ib_go) begin
						state <= frt_pkg::ST_SWRST;
						tmr <= 20'(SWRES_CYC);
					end else if (do_resume) begin
						state <= frt_pkg::ST_WAKE;
						tmr <= 20'(WAKE_CYC);
					end
				end
				frt_pkg::ST_WAKE, frt_pkg::ST_SWRST: begin
					if (tmr <= 20'h1) begin
						state <= frt_pkg::ST_IDLE;
					end else begin
						tmr <= tmr - 20'h1;
					end
				end
				frt_pkg::ST_HOLD: begin
					state <= frt_pkg::ST_IDLE;
				end
				default: begin
					state <= frt_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_write_enable_latch <= 1'b0;
		end else if (clr_vol || do_term) begin
			o_write_enable_latch <= 1'b0;
		end else if (i_wel_set && idle) begin
			o_write_enable_latch <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n || clr_vol) begin
			o_abort_enable_bit <= 1'b0;
		end else if (do_wr2) begin
			o_abort_enable_bit <= arg[`FRT_ABORT_ENABLE_BIT_POS];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n || clr_vol) begin
			o_octal_mode <= 1'b0;
		end else if (i_octal_enter && idle) begin
			o_octal_mode <= 1'b1;
		end
	end

	// the error flag survives every wake path but power loss;
	// a new error wins over a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_program_erase_error_flag <= 1'b0;
		end else if (i_pe_error) begin
			o_program_erase_error_flag <= 1'b1;
		end else if (i_pe_error_clr) begin
			o_program_erase_error_flag <= 1'b0;
		end
	end

	// abort request stands until the array stops or time runs out
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_abort_op <= 1'b0;
			ab_cnt <= 20'h0;
		end else if (stop_ops) begin
			o_abort_op <= 1'b1;
			ab_cnt <= 20'(ABORT_CYC);
		end else if (o_abort_op) begin
			if (!i_op_busy || ab_cnt <= 20'h1) begin
				o_abort_op <= 1'b0;
			end else begin
				ab_cnt <= ab_cnt - 20'h1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			puw_cnt <= 20'(PUW_CYC);
			o_pe_allowed <= 1'b0;
		end else begin
			if (puw_cnt != 20'h0) begin
				puw_cnt <= puw_cnt - 20'h1;
			end
			o_pe_allowed <= puw_cnt == 20'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_lowest_power_state <= 1'b0;
			o_busy_flag <= 1'b0;
			o_vol_reset <= 1'b0;
			o_prot_reset <= 1'b0;
		end else begin
			o_lowest_power_state <= in_lps;
			o_busy_flag <= i_op_busy || !idle;
			o_vol_reset <= clr_vol;
			o_prot_reset <= do_swr || ib_go || (!rpin_s && in_lps);
		end
	end

	always_comb begin
		sb1 = 8'h00;
		sb1[`FRT_SB1_BUSY] = o_busy_flag;
		sb1[`FRT_SB1_WEL] = o_write_enable_latch;
		sb1[`FRT_SB1_EPE] = o_program_erase_error_flag;
		if (in_lps) begin
			sb1 = `FRT_SB1_LPS;
		end
	end

	// status read; output moves on falling clock edges seen late
	// through the synchroniser, fine for the slow serial clock only
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || frm_start || frm_end) begin
			rd_on <= 1'b0;
			sh_out <= 8'h00;
			o_dq <= 8'h00;
			o_dq_oe <= 8'h00;
		end else if (byte_done && byte_cnt == 2'h0) begin
			rd_on <= sh_in == `FRT_OP_RD_SB1 && (idle || in_lps);
			sh_out <= sb1;
		end else if (rd_on && sck_fall) begin
			if (o_octal_mode) begin
				o_dq <= sh_out;
				o_dq_oe <= `FRT_OE_OCT;
			end else begin
				o_dq[`FRT_DQ_SO] <= sh_out[7];
				o_dq_oe <= `FRT_OE_SPI;
				sh_out <= {sh_out[6:0], sh_out[7]};
			end
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_in_lps;
		state == frt_pkg::ST_LPS;
	endsequence

	sequence s_left_lps;
		state != frt_pkg::ST_LPS;
	endsequence

	a_lps_exit_path: assert property (
		s_in_lps ##1 s_left_lps |-> state inside {frt_pkg::ST_WAKE,
			frt_pkg::ST_SWRST, frt_pkg::ST_HOLD})
		else $error("lowest power left by wrong path");

	a_cs_no_wake: assert property (
		s_in_lps and (frm_start || frm_end) && !ib_go && !do_resume &&
			rpin_s |=> s_in_lps)
		else $error("chip select woke the device");

	a_term_abort: assert property (
		do_term && rpin_s |=> o_abort_op && !o_write_enable_latch)
		else $error("terminate did not abort");

	a_term_keep_cfg: assert property (
		do_term && rpin_s |=> $stable(o_abort_enable_bit) &&
			$stable(o_octal_mode))
		else $error("terminate changed configuration");

	a_abort_cause: assert property (
		$rose(o_abort_op) |-> $past(stop_ops))
		else $error("abort without cause");

	a_unaligned_end: assert property (
		frm_end && bit_cnt != 3'h0 && rpin_s && !o_abort_op
			|=> !o_abort_op)
		else $error("unaligned frame aborted");

	a_swr_hold: assert property (
		do_swr && rpin_s && SWRES_CYC > 8 |=>
			(state == frt_pkg::ST_SWRST && !o_octal_mode)[*8])
		else $error("software reset window broken");

	a_lps_status: assert property (
		s_in_lps and rd_on && sck_fall && !o_octal_mode
			|=> o_dq[`FRT_DQ_SO])
		else $error("status bit not one in lowest power");

	a_puw_block: assert property (
		puw_cnt > 20'h1 |=> !o_pe_allowed)
		else $error("program allowed too early");

	a_pin_hold: assert property (
		!rpin_s |=> state == frt_pkg::ST_HOLD && o_vol_reset)
		else $error("reset pin not honoured");

endmodule : frt_ctrl

/* verilog/frt_defs.svh */
// Purpose: shared constants of the reset and terminate control block
// Assumes: 100 MHz internal clock
// Notes: times are in ns, cycle counts derive from them
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

`define FRT_OP_TERM 8'hF0
`define FRT_OP_CONFIRM 8'hD0
`define FRT_OP_RST_EN 8'h66
`define FRT_OP_RST 8'h99
`define FRT_OP_WR_SB2 8'h31
`define FRT_OP_RESUME 8'hAB
`define FRT_OP_RD_SB1 8'h05
`define FRT_OP_LPS 8'h79
`define FRT_INBAND_PAT 4'h5
`define FRT_ABORT_ENABLE_BIT_POS 3
`define FRT_SB1_BUSY 0
`define FRT_SB1_WEL 1
`define FRT_SB1_EPE 5
`define FRT_SB1_LPS 8'hFF
`define FRT_DQ_SI 0
`define FRT_DQ_SO 1
`define FRT_OE_SPI 8'h02
`define FRT_OE_OCT 8'hFF
`define FRT_SYNC_INIT 4'h9

`define FRT_CLK_NS 10
`define FRT_ABORT_NS 20000
`define FRT_SWRES_NS 30000
`define FRT_WAKE_NS 50000
`define FRT_PUW_NS 1000000
`define FRT_ABORT_CYC (`FRT_ABORT_NS / `FRT_CLK_NS)
`define FRT_SWRES_CYC ((`FRT_SWRES_NS + `FRT_CLK_NS - 1) / `FRT_CLK_NS)
`define FRT_WAKE_CYC ((`FRT_WAKE_NS + `FRT_CLK_NS - 1) / `FRT_CLK_NS)
`define FRT_PUW_CYC ((`FRT_PUW_NS + `FRT_CLK_NS - 1) / `FRT_CLK_NS)

`endif

/* verilog/frt_pkg.sv */
// Purpose: types of the reset and terminate control block
// Assumes: nothing
// Notes: one-hot state codes
package frt_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LPS = 5'h02,
		ST_WAKE = 5'h04,
		ST_SWRST = 5'h08,
		ST_HOLD = 5'h10
	} frt_state_t;
endpackage : frt_pkg

/* verilog/frt_sync.sv */
// Purpose: three-stage pin synchroniser, per bit
// Assumes: inputs asynchronous to i_clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
module frt_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (!i_reset_n) begin
					s1[g] <= INIT[g];
					s2[g] <= INIT[g];
					s3[g] <= INIT[g];
					o_q[g] <= INIT[g];
				end else begin
					s1[g] <= i_d[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g]) begin
						o_q[g] <= s3[g];
					end
				end
			end
		end
	endgenerate
endmodule : frt_sync
